/* src/urms_pkg.sv */
// Package for the receive and modem status block.
// Assumes a 16-bit register port with one-cycle read latency.
package urms_pkg;

	// -------------------------------------------------------------
	// Register offsets
	// -------------------------------------------------------------
	localparam logic [31:0] OFF_MODEM_LINE_STATUS   = 32'h5000_1018;
	localparam logic [31:0] OFF_SCRATCH_STORAGE     = 32'h5000_101c;
	localparam logic [31:0] OFF_RECEIVE_LINE_STATUS = 32'h5000_1014;
	localparam logic [31:0] OFF_RECEIVE_BUFFER      = 32'h5000_1000;
	localparam logic [31:0] OFF_MODEM_CONTROL       = 32'h5000_1010;
	localparam logic [31:0] OFF_FIFO_MODE           = 32'h5000_1008;
	localparam logic [31:0] OFF_IRQ_STATUS          = 32'h5000_1020;
	localparam logic [31:0] OFF_IRQ_MASK            = 32'h5000_1024;

	// -------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------
	localparam int LSR_DATA_AVAIL_BIT = 0;
	localparam int LSR_OVERRUN_BIT    = 1;
	localparam int MSR_CTS_CHG_BIT    = 0;
	localparam int MSR_CTS_BIT        = 4;
	localparam int MCR_RTS_BIT        = 1;
	localparam int MCR_LOOPBACK_BIT   = 4;
	localparam int FIFO_EN_BIT        = 0;
	localparam int SCRATCH_W          = 8;

	// Interrupt status bits
	localparam int IRQ_OVERRUN_BIT = 0;
	localparam int IRQ_CTS_CHG_BIT = 1;
	localparam int IRQ_RX_DATA_BIT = 2;
	localparam int IRQ_W           = 3;

	// -------------------------------------------------------------
	// Reset values and default FIFO depth
	// -------------------------------------------------------------
	localparam logic [7:0]  SCRATCH_RST = 8'h00;
	localparam logic [7:0]  MCR_RST     = 8'h00;
	localparam logic [15:0] REG_RST     = 16'h0000;
	localparam int          FIFO_DEPTH  = 16;

endpackage

/* src/urms_rx_fifo.sv */
// Receive FIFO of flip-flops, indexed by read and write pointers.
// Drops a push while full and a pop while empty.
module urms_rx_fifo #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic             clr,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head_data,
	output logic                  empty,
	output logic                  full
);
	localparam int AW = $clog2(DEPTH);

	// Pointer wrap bit needs a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("urms_rx_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wr_ptr_r;
	logic [AW:0]      rd_ptr_r;
	wire              do_push = push && !full;
	wire              do_pop  = pop && !empty;

	assign empty     = (wr_ptr_r == rd_ptr_r);
	assign full      = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) &&
	                   (wr_ptr_r[AW] != rd_ptr_r[AW]);
	assign head_data = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else if (clr) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (do_push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (do_pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (do_push)
			mem_r[wr_ptr_r[AW-1:0]] <= push_data;
	end
endmodule

/* src/urms_sticky.sv */
// One sticky status bit: set by an event, cleared by a trigger.
// Set wins over a clear arriving in the same cycle.
module urms_sticky (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			q <= 1'b0;
		else if (set)
			q <= 1'b1;
		else if (clr)
			q <= 1'b0;
	end
endmodule

/* src/urms_top.sv */
// Receive line status, modem status and scratch registers of a UART.
// Assumes received characters arrive as one-cycle strobes with data,
// and that cts_b is synchronous to ref_clk.
//
// Our own choice: strobed register access.
module urms_top #(
	parameter int FIFO_DEPTH = urms_pkg::FIFO_DEPTH
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// Register port
	input  wire logic [31:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Receiver side
	input  wire logic        rx_char_done,
	input  wire logic [7:0]  rx_char,
	// Modem lines
	input  wire logic        cts_b,
	output logic             rts_b,
	// Interrupt
	output logic             irq
);
	// Depth must suit the FIFO pointer logic
	if (FIFO_DEPTH < 2 ||
	    (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("urms_top: FIFO_DEPTH must be a power of two >= 2");
	end

	// -------------------------------------------------------------
	// Address decode
	// -------------------------------------------------------------
	wire sel_msr  = (reg_addr == urms_pkg::OFF_MODEM_LINE_STATUS);
	wire sel_scr  = (reg_addr == urms_pkg::OFF_SCRATCH_STORAGE);
	wire sel_lsr  = (reg_addr == urms_pkg::OFF_RECEIVE_LINE_STATUS);
	wire sel_rbr  = (reg_addr == urms_pkg::OFF_RECEIVE_BUFFER);
	wire sel_mcr  = (reg_addr == urms_pkg::OFF_MODEM_CONTROL);
	wire sel_fmd  = (reg_addr == urms_pkg::OFF_FIFO_MODE);
	wire sel_ists = (reg_addr == urms_pkg::OFF_IRQ_STATUS);
	wire sel_imsk = (reg_addr == urms_pkg::OFF_IRQ_MASK);

	wire rd_msr = reg_rd && sel_msr;
	wire rd_lsr = reg_rd && sel_lsr;
	wire rd_rbr = reg_rd && sel_rbr;
	wire wr_scr = reg_wr && sel_scr;
	wire wr_mcr = reg_wr && sel_mcr;
	wire wr_fmd = reg_wr && sel_fmd;
	wire wr_ist = reg_wr && sel_ists;
	wire wr_imk = reg_wr && sel_imsk;

	// -------------------------------------------------------------
	// Control registers
	// -------------------------------------------------------------
	logic [7:0]  scratch_byte_r;
	logic [7:0]  modem_control_r;
	logic        fifo_en_r;
	logic [urms_pkg::IRQ_W-1:0] irq_mask_r;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			scratch_byte_r  <= urms_pkg::SCRATCH_RST;
			modem_control_r <= urms_pkg::MCR_RST;
			fifo_en_r       <= 1'b0;
			irq_mask_r      <= '0;
		end else begin
			if (wr_scr)
				scratch_byte_r <= reg_wdata[7:0];
			if (wr_mcr)
				modem_control_r <= reg_wdata[7:0];
			if (wr_fmd)
				fifo_en_r <= reg_wdata[urms_pkg::FIFO_EN_BIT];
			if (wr_imk)
				irq_mask_r <= reg_wdata[urms_pkg::IRQ_W-1:0];
		end
	end

	wire loopback = modem_control_r[urms_pkg::MCR_LOOPBACK_BIT];
	wire rts_bit  = modem_control_r[urms_pkg::MCR_RTS_BIT];

	// Outgoing line held deasserted during loopback
	assign rts_b = loopback ? 1'b1 : !rts_bit;

	// -------------------------------------------------------------
	// Receive path
	// -------------------------------------------------------------
	logic [7:0] receive_buffer_r;
	logic       rbr_full_r;
	logic       fifo_empty;
	logic       fifo_full;
	logic [7:0] fifo_head;

	wire fifo_push  = fifo_en_r && rx_char_done && !fifo_full;
	wire fifo_pop   = fifo_en_r && rd_rbr;
	// Mode change flushes held data
	wire fifo_clr   = wr_fmd;

	wire ovr_nofifo = !fifo_en_r && rx_char_done && rbr_full_r;
	wire ovr_fifo   = fifo_en_r && rx_char_done && fifo_full;
	wire overrun_ev = ovr_nofifo || ovr_fifo;

	urms_rx_fifo #(
		.DEPTH    (FIFO_DEPTH),
		.WIDTH    (8)
	) u_fifo (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.clr      (fifo_clr),
		.push     (fifo_push),
		.push_data(rx_char),
		.pop      (fifo_pop),
		.head_data(fifo_head),
		.empty    (fifo_empty),
		.full     (fifo_full)
	);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			receive_buffer_r <= 8'h00;
			rbr_full_r       <= 1'b0;
		end else if (wr_fmd) begin
			rbr_full_r <= 1'b0;
		end else if (!fifo_en_r && rx_char_done) begin
			receive_buffer_r <= rx_char;
			rbr_full_r       <= 1'b1;
		end else if (!fifo_en_r && rd_rbr) begin
			rbr_full_r <= 1'b0;
		end
	end

	// Empty FIFO drops the flag directly
	wire data_avail = fifo_en_r ? !fifo_empty : rbr_full_r;
	wire [7:0] rbr_view = fifo_en_r ? fifo_head : receive_buffer_r;

	// Overrun: set wins over the clearing read
	logic overrun_q;
	urms_sticky u_ovr (
		.ref_clk(ref_clk),
		.rst_b  (rst_b),
		.set    (overrun_ev),
		.clr    (rd_lsr),
		.q      (overrun_q)
	);

	// -------------------------------------------------------------
	// Clear-to-send and change detect
	// -------------------------------------------------------------
	wire cts_now = loopback ? rts_bit : !cts_b;

	logic cts_prev_r;
	logic rst_seen_r;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cts_prev_r <= 1'b0;
			rst_seen_r <= 1'b1;
		end else begin
			cts_prev_r <= cts_now;
			rst_seen_r <= 1'b0;
		end
	end

	// Previous level treated as deasserted across reset
	wire cts_edge = (cts_now != cts_prev_r) && !rst_seen_r;
	wire cts_rst  = rst_seen_r && cts_now;

	logic cts_chg_q;
	urms_sticky u_dcts (
		.ref_clk(ref_clk),
		.rst_b  (rst_b),
		.set    (cts_edge || cts_rst),
		.clr    (rd_msr),
		.q      (cts_chg_q)
	);

	// -------------------------------------------------------------
	// Interrupt status and mask
	// -------------------------------------------------------------
	wire  [urms_pkg::IRQ_W-1:0] irq_sts;
	wire  [urms_pkg::IRQ_W-1:0] irq_set;
	wire  [urms_pkg::IRQ_W-1:0] irq_clr;

	assign irq_set[urms_pkg::IRQ_OVERRUN_BIT] = overrun_ev;
	assign irq_set[urms_pkg::IRQ_CTS_CHG_BIT] = cts_edge || cts_rst;
	assign irq_set[urms_pkg::IRQ_RX_DATA_BIT] =
		fifo_push || (!fifo_en_r && rx_char_done);
	assign irq_clr = wr_ist ? reg_wdata[urms_pkg::IRQ_W-1:0] : '0;

	genvar gi;
	generate
		for (gi = 0; gi < urms_pkg::IRQ_W; gi++) begin : g_irq
			urms_sticky u_bit (
				.ref_clk(ref_clk),
				.rst_b  (rst_b),
				.set    (irq_set[gi]),
				.clr    (irq_clr[gi]),
				.q      (irq_sts[gi])
			);
		end
	endgenerate

	assign irq = |(irq_sts & irq_mask_r);

	// -------------------------------------------------------------
	// Read data
	// -------------------------------------------------------------
	logic [15:0] lsr_view;
	logic [15:0] msr_view;
	logic [15:0] rdata_nxt;
	logic [15:0] reg_rdata_r;

	always_comb begin
		lsr_view = urms_pkg::REG_RST;
		lsr_view[urms_pkg::LSR_DATA_AVAIL_BIT] = data_avail;
		lsr_view[urms_pkg::LSR_OVERRUN_BIT]    = overrun_q;
		msr_view = urms_pkg::REG_RST;
		msr_view[urms_pkg::MSR_CTS_BIT]     = cts_now;
		msr_view[urms_pkg::MSR_CTS_CHG_BIT] = cts_chg_q;
	end

	always_comb begin
		rdata_nxt = urms_pkg::REG_RST;
		if (sel_msr)
			rdata_nxt = msr_view;
		else if (sel_scr)
			rdata_nxt = {8'h00, scratch_byte_r};
		else if (sel_lsr)
			rdata_nxt = lsr_view;
		else if (sel_rbr)
			rdata_nxt = {8'h00, rbr_view};
		else if (sel_mcr)
			rdata_nxt = {8'h00, modem_control_r};
		else if (sel_fmd)
			rdata_nxt = {15'h0000, fifo_en_r};
		else if (sel_ists)
			rdata_nxt = {13'h0000, irq_sts};
		else if (sel_imsk)
			rdata_nxt = {13'h0000, irq_mask_r};
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata_r <= urms_pkg::REG_RST;
		else if (reg_rd)
			reg_rdata_r <= rdata_nxt;
		else
			reg_rdata_r <= urms_pkg::REG_RST;
	end

	assign reg_rdata = reg_rdata_r;
endmodule

/* dv/urms_sva.sv */
// Checker for the receive line, modem status and scratch registers.
// Sees only urms_top ports; bound to it after the module.
module urms_sva (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic [31:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        rx_char_done,
	input wire logic        cts_b
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	logic       lb_r;
	logic       rts_r;
	logic       fifo_r;
	logic [7:0] scr_r;
	wire logic  msr_a = reg_addr == urms_pkg::OFF_MODEM_LINE_STATUS;
	wire logic  lsr_a = reg_addr == urms_pkg::OFF_RECEIVE_LINE_STATUS;
	wire logic  scr_a = reg_addr == urms_pkg::OFF_SCRATCH_STORAGE;
	wire logic  mcr_w = reg_wr && reg_addr == urms_pkg::OFF_MODEM_CONTROL;
	wire logic  fm_w  = reg_wr && reg_addr == urms_pkg::OFF_FIFO_MODE;

	// ----------------------------------------
	// Shadow copies of written fields
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			{lb_r, rts_r, fifo_r} <= 3'h0;
			scr_r <= 8'h00;
		end else begin
			if (mcr_w)
				{lb_r, rts_r} <= {reg_wdata[4], reg_wdata[1]};
			if (fm_w)
				fifo_r <= reg_wdata[0];
			if (reg_wr && scr_a)
				scr_r <= reg_wdata[7:0];
		end
	end

	sequence s_msr_rd;
		reg_rd && msr_a;
	endsequence
	sequence s_lsr_rd;
		reg_rd && lsr_a;
	endsequence
	sequence s_quiet;
		!lb_r && $stable(cts_b);
	endsequence

	property p_cts;
		reg_rd && msr_a && !lb_r && !$past(mcr_w) && $stable(cts_b)
			|=> reg_rdata[4] == !$past(cts_b);
	endproperty
	a_cts: assert property (p_cts) else $error("cts bit wrong");
	property p_lb;
		reg_rd && msr_a && lb_r && !$past(mcr_w)
			|=> reg_rdata[4] == $past(rts_r);
	endproperty
	a_lb: assert property (p_lb) else $error("loop cts wrong");
	property p_scr;
		reg_rd && scr_a |=> reg_rdata == {8'h00, $past(scr_r)};
	endproperty
	a_scr: assert property (p_scr) else $error("scratch wrong");
	property p_chg_set;
		(!lb_r && $changed(cts_b)) ##1 s_msr_rd |=> reg_rdata[0];
	endproperty
	a_chg_set: assert property (p_chg_set) else $error("no change");
	property p_chg_clr;
		s_quiet [*2] ##0 s_msr_rd ##1 (reg_rd && msr_a && !lb_r
			&& $stable(cts_b)) |=> !reg_rdata[0];
	endproperty
	a_chg_clr: assert property (p_chg_clr) else $error("chg kept");
	property p_avail;
		(rx_char_done && !reg_wr) ##1 (!reg_rd && !reg_wr) ##1 s_lsr_rd
			|=> reg_rdata[0];
	endproperty
	a_avail: assert property (p_avail) else $error("no data");
	property p_ovr_clr;
		!rx_char_done [*2] ##0 s_lsr_rd ##1 (reg_rd && lsr_a && !rx_char_done)
			|=> !reg_rdata[1];
	endproperty
	a_ovr_clr: assert property (p_ovr_clr) else $error("ovr kept");
	property p_ovr;
		(rx_char_done && !fifo_r && !reg_wr) [*2] ##1 !reg_rd ##1 s_lsr_rd
			|=> reg_rdata[1];
	endproperty
	a_ovr: assert property (p_ovr) else $error("no overrun");
endmodule

bind urms_top urms_sva u_sva (
	.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .rx_char_done(rx_char_done), .cts_b(cts_b)
);

/* dv/urms_modem.sv */
// Modem model driving the active-low clear-to-send line.
// Assumes the bench sets ready_req; the line follows one edge later.
module urms_modem (
	input  wire logic ref_clk,
	input  wire logic ready_req,
	output logic      cts_b
);
	timeunit 1ns;
	timeprecision 1ns;
	initial cts_b = 1'b1;
	always @(posedge ref_clk)
		cts_b <= !ready_req;
endmodule

/* dv/uart_rx_modem_status_tb.sv */
// Testbench for the receive line, modem status and scratch registers.
// Register port and receiver strobes from tasks; modem model on cts_b.
module uart_rx_modem_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int          DEPTH = 4;
	localparam logic [31:0] A_LSR = urms_pkg::OFF_RECEIVE_LINE_STATUS;
	localparam logic [31:0] A_MSR = urms_pkg::OFF_MODEM_LINE_STATUS;
	localparam logic [31:0] A_SCR = urms_pkg::OFF_SCRATCH_STORAGE;
	localparam logic [31:0] A_RBR = urms_pkg::OFF_RECEIVE_BUFFER;
	localparam logic [31:0] A_MCR = urms_pkg::OFF_MODEM_CONTROL;
	localparam logic [31:0] A_IST = urms_pkg::OFF_IRQ_STATUS;
	localparam logic [31:0] A_IMK = urms_pkg::OFF_IRQ_MASK;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [31:0] reg_addr = 32'h0;
	logic [15:0] reg_wdata = 16'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        rx_char_done = 1'b0;
	logic [7:0]  rx_char = 8'h00;
	logic        cts_req = 1'b1;
	wire logic [15:0] reg_rdata;
	wire logic   cts_b;
	wire logic   rts_b;
	wire logic   irq;
	int          error_cnt = 0;
	int          n_compared = 0;

	always #25 ref_clk = ~ref_clk;
	urms_top #(.FIFO_DEPTH(DEPTH)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_char_done(rx_char_done),
		.rx_char(rx_char), .cts_b(cts_b), .rts_b(rts_b), .irq(irq));
	urms_modem u_modem (.ref_clk(ref_clk), .ready_req(cts_req),
		.cts_b(cts_b));

	// ----------------------------------------
	// Access and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({15'h0, got}, {15'h0, exp});
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Optional second read back to back at the same address
	task automatic rd(input logic [31:0] a, input logic [15:0] e,
		input logic [15:0] e2 = 16'h0, input bit two = 1'b0);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		if (!two)
			reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		if (two) begin
			@(posedge ref_clk);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata, e2);
		end
	endtask
	task automatic rx(input logic [7:0] c, input int n);
		@(posedge ref_clk);
		rx_char_done <= 1'b1;
		for (int i = 0; i < n; i++) begin
			rx_char <= c + 8'(i);
			@(posedge ref_clk);
		end
		rx_char_done <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge ref_clk);
		error_cnt++;
		print_verdict();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(A_MSR, 16'h0011, 16'h0010, 1'b1);
		rd(A_SCR, 16'h0000);
		rd(A_LSR, 16'h0000);
		rd(32'h5000_1040, 16'h0000);
		@(posedge ref_clk);
		cts_req <= 1'b0;
		@(posedge ref_clk);
		rd(A_MSR, 16'h0001, 16'h0000, 1'b1);
		wr(A_MCR, 16'h0012);
		rd(A_MSR, 16'h0011, 16'h0010, 1'b1);
		chk1(rts_b, 1'b1);
		wr(A_MCR, 16'h0010);
		rd(A_MSR, 16'h0001, 16'h0000, 1'b1);
		wr(A_MCR, 16'h0002);
		rd(A_MCR, 16'h0002);
		rd(A_MSR, 16'h0000);
		chk1(rts_b, 1'b0);
		wr(A_SCR, 16'hffff);
		rd(A_SCR, 16'h00ff);
		wr(A_MSR, 16'hffff);
		rd(A_MSR, 16'h0000);
		rx(8'h5a, 1);
		rd(A_LSR, 16'h0001);
		rd(A_RBR, 16'h005a);
		rd(A_LSR, 16'h0000);
		rx(8'h11, 2);
		rd(A_LSR, 16'h0003, 16'h0001, 1'b1);
		rd(A_RBR, 16'h0012);
		rd(A_LSR, 16'h0000);
		wr(urms_pkg::OFF_FIFO_MODE, 16'h0001);
		rx(8'h40, DEPTH + 1);
		rd(A_LSR, 16'h0003, 16'h0001, 1'b1);
		for (int i = 0; i < DEPTH; i++)
			rd(A_RBR, 16'h0040 + 16'(i));
		rd(A_LSR, 16'h0000);
		chk1(irq, 1'b0);
		rd(A_IST, 16'h0007);
		wr(A_IST, 16'h0007);
		rd(A_IST, 16'h0000);
		wr(A_IMK, 16'h0004);
		rx(8'h01, 1);
		#1 chk1(irq, 1'b1);
		rd(A_IST, 16'h0004);
		wr(A_IMK, 16'h0000);
		#1 chk1(irq, 1'b0);
		wr(A_IST, 16'h0004);
		wr(A_IMK, 16'h0004);
		#1 chk1(irq, 1'b0);
		// Mid-run reset with clear-to-send asserted
		@(posedge ref_clk);
		cts_req <= 1'b1;
		wr(A_SCR, 16'h00a5);
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(A_MSR, 16'h0011, 16'h0010, 1'b1);
		rd(A_SCR, 16'h0000);
		rd(A_LSR, 16'h0000);
		print_verdict();
	end
endmodule
